// ---- rtl/dcis_sequencer.sv ----
/*
  Dual channel insertion sequencer: lockout, reset, off, initial timing,
  per channel start-up, monitoring and a shared fault latch, with an
  APB slave for a control and a status register.
  Assumes comparator results arrive asynchronously and that analog
  drivers follow the mode codes of dcis_drv_t.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcis_map.svh"
module dcis_sequencer (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Comparator results
  input  wire dcis_pkg::dcis_cmp_t cmp_in,
  // Drive controls and open-drain output levels
  output var  dcis_pkg::dcis_drv_t drv,
  output logic                   fault_line_o,
  output logic                   first_power_good_o,
  output logic                   second_power_good_o
);

  ////////////////////////////////////////////////////////////////////
  // Synchroniser.

  dcis_pkg::dcis_cmp_t cmp_s1;
  dcis_pkg::dcis_cmp_t c;
  logic [1:0]          en_prev;

  // Two stages; only c is read by logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_s1  <= '0;
      c       <= '0;
      en_prev <= 2'h0;
    end else begin
      cmp_s1  <= cmp_in;
      c       <= cmp_s1;
      en_prev <= {c.second_enable_on, c.first_enable_on};
    end
  end

  logic en_cross;
  logic en_any;
  assign en_cross = en_prev != {c.second_enable_on, c.first_enable_on};
  assign en_any   = c.first_enable_on | c.second_enable_on;

  ////////////////////////////////////////////////////////////////////
  // Glitch filters: a condition counts only once it has persisted.

  localparam int NFLT = 6;
  localparam logic [65:0] FLT_LIM = {
    11'(`DCIS_CYC(`DCIS_SLOW_T_NS)),
    11'(`DCIS_CYC(`DCIS_FAST_T_NS)),
    11'(`DCIS_CYC(`DCIS_FAST_T_NS)),
    11'(`DCIS_CYC(`DCIS_OV_T_NS)),
    11'(`DCIS_CYC(`DCIS_OV_T_NS)),
    11'(`DCIS_CYC(`DCIS_LOCK_T_NS))
  };

  logic [1:0]      armed;
  logic            filter_fitted;
  logic            slow_trip;
  logic [NFLT-1:0] flt_raw;
  logic [NFLT-1:0] flt_out;

  assign slow_trip = (armed[0] & c.first_sense_slow) |
                     (armed[1] & c.second_sense_slow);
  assign flt_raw = {
    slow_trip,
    c.second_sense_fast,
    c.first_sense_fast,
    c.second_feedback_ov,
    c.first_feedback_ov,
    ~(c.first_supply_ok & c.second_supply_ok)
  };

  for (genvar g = 0; g < NFLT; g++) begin : g_flt
    logic [10:0] cnt;
    logic [10:0] next_cnt;
    logic [10:0] lim;
    assign lim        = FLT_LIM[g*11 +: 11];
    assign flt_out[g] = cnt == lim;
    // Count while the raw condition holds, restart when it drops.
    always_comb begin
      next_cnt = 11'h000;
      if (flt_raw[g]) begin
        next_cnt = (cnt == lim) ? cnt : cnt + 11'h001;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt <= 11'h000;
      end else begin
        cnt <= next_cnt;
      end
    end
  end

  logic lock_flt;
  logic sup_ok;
  logic filt_fault;
  assign lock_flt = flt_out[0];
  assign sup_ok   = c.first_supply_ok & c.second_supply_ok;
  // An open filter pin falls back to the internal response time.
  assign filt_fault = filter_fitted ? (c.filter_high & slow_trip)
                                    : flt_out[5];

  ////////////////////////////////////////////////////////////////////
  // Sequencer, fault latch and arming.

  dcis_pkg::dcis_state_t state;
  dcis_pkg::dcis_state_t next_state;
  logic                  fault_latch;
  logic                  next_latch;
  logic [1:0]            next_armed;
  logic                  fault_set;
  logic                  init_go;
  logic                  latch_clr;

  assign fault_set = flt_out[1] | flt_out[2] |
                     flt_out[3] | flt_out[4] |
                     filt_fault |
                     ~c.fault_line_high;
  assign init_go = en_any & c.first_gate_low &
                   c.second_gate_low & c.timer_low;
  assign latch_clr = (state == dcis_pkg::ST_LOCK) |
                     (state == dcis_pkg::ST_RESET) |
                     lock_flt | ~c.first_enable_rst;

  // Next state; lockout, then global reset, then faults take priority.
  always_comb begin
    next_state = state;
    if (state == dcis_pkg::ST_LOCK) begin
      if (sup_ok) next_state = dcis_pkg::ST_RESET;
    end else if (lock_flt) begin
      next_state = dcis_pkg::ST_LOCK;
    end else if (!c.first_enable_rst) begin
      next_state = dcis_pkg::ST_RESET;
    end else if (fault_latch) begin
      next_state = dcis_pkg::ST_FAULT;
    end else begin
      unique case (state)
        dcis_pkg::ST_RESET: next_state = dcis_pkg::ST_OFF;
        dcis_pkg::ST_OFF: begin
          if (init_go) next_state = dcis_pkg::ST_INIT;
        end
        dcis_pkg::ST_INIT: begin
          if (en_cross || !en_any) begin
            next_state = dcis_pkg::ST_OFF;
          end else if (c.timer_high) begin
            next_state = dcis_pkg::ST_IDIS;
          end
        end
        dcis_pkg::ST_IDIS: begin
          if (en_cross || !en_any) begin
            next_state = dcis_pkg::ST_OFF;
          end else if (c.timer_low && !c.filter_high &&
                       c.fault_line_high) begin
            next_state = c.first_enable_on ? dcis_pkg::ST_UP1
                                           : dcis_pkg::ST_UP2;
          end
        end
        dcis_pkg::ST_UP1: begin
          if (c.timer_high || !c.first_enable_on) begin
            next_state = dcis_pkg::ST_D1;
          end
        end
        dcis_pkg::ST_D1: begin
          if (c.timer_low) begin
            next_state = (c.second_enable_on && !armed[1])
                         ? dcis_pkg::ST_UP2
                         : dcis_pkg::ST_MON;
          end
        end
        dcis_pkg::ST_UP2: begin
          if (c.timer_high || !c.second_enable_on) begin
            next_state = dcis_pkg::ST_D2;
          end
        end
        dcis_pkg::ST_D2: begin
          if (c.timer_low) next_state = dcis_pkg::ST_MON;
        end
        dcis_pkg::ST_MON: begin
          // Each channel powers up on its own enable.
          if (c.first_enable_on && !armed[0]) begin
            next_state = dcis_pkg::ST_UP1;
          end else if (c.second_enable_on && !armed[1]) begin
            next_state = dcis_pkg::ST_UP2;
          end
        end
        dcis_pkg::ST_FAULT: next_state = dcis_pkg::ST_FAULT;
        default: next_state = dcis_pkg::ST_LOCK;
      endcase
    end
  end

  // Latch: the clear wins while lockout or global reset is present.
  always_comb begin
    next_latch = fault_latch | fault_set;
    if (latch_clr) next_latch = 1'b0;
    next_armed = armed;
    if (state == dcis_pkg::ST_UP1 && c.timer_high && c.first_enable_on) begin
      next_armed[0] = 1'b1;
    end
    if (state == dcis_pkg::ST_UP2 && c.timer_high && c.second_enable_on) begin
      next_armed[1] = 1'b1;
    end
    if (!c.first_enable_on) next_armed[0] = 1'b0;
    if (!c.second_enable_on) next_armed[1] = 1'b0;
    if (latch_clr || fault_latch || state == dcis_pkg::ST_OFF) begin
      next_armed = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= dcis_pkg::ST_LOCK;
      fault_latch <= 1'b0;
      armed       <= 2'h0;
    end else begin
      state       <= next_state;
      fault_latch <= next_latch;
      armed       <= next_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Drive outputs, registered.

  // Gate mode of one channel outside lockout, reset and fault.
  function automatic dcis_pkg::dcis_gate_t gmode(
    input logic on, input logic arm, input logic up, input logic acl);
    gmode = dcis_pkg::G_WEAK;
    if (on && arm) begin
      gmode = dcis_pkg::G_UP;
    end else if (on && up) begin
      gmode = acl ? dcis_pkg::G_HOLD : dcis_pkg::G_UP;
    end
  endfunction

  dcis_pkg::dcis_drv_t next_drv;
  logic                in_lock;
  logic                in_init;
  assign in_lock = state == dcis_pkg::ST_LOCK;
  assign in_init = (state == dcis_pkg::ST_INIT) ||
                   (state == dcis_pkg::ST_IDIS);

  always_comb begin
    next_drv.first_gate_drive  = gmode(c.first_enable_on, armed[0],
      state == dcis_pkg::ST_UP1, c.first_acl_over);
    next_drv.second_gate_drive = gmode(c.second_enable_on, armed[1],
      state == dcis_pkg::ST_UP2, c.second_acl_over);
    if (in_lock || fault_latch || state == dcis_pkg::ST_FAULT) begin
      next_drv.first_gate_drive  = dcis_pkg::G_FAST;
      next_drv.second_gate_drive = dcis_pkg::G_FAST;
    end else if (state == dcis_pkg::ST_RESET) begin
      next_drv.first_gate_drive  = dcis_pkg::G_WEAK;
      next_drv.second_gate_drive = dcis_pkg::G_WEAK;
    end
    unique case (1'b1)
      state == dcis_pkg::ST_INIT: next_drv.timer_mode = dcis_pkg::T_SMALL;
      state == dcis_pkg::ST_UP1,
      state == dcis_pkg::ST_UP2:  next_drv.timer_mode = dcis_pkg::T_LARGE;
      state == dcis_pkg::ST_IDIS,
      state == dcis_pkg::ST_D1,
      state == dcis_pkg::ST_D2:   next_drv.timer_mode = dcis_pkg::T_DIS;
      default:                    next_drv.timer_mode = dcis_pkg::T_DN;
    endcase
    next_drv.filter_pull_up = slow_trip & ~in_lock;
    next_drv.fault_pull_up  = ~fault_latch;
    next_drv.fault_oe_n     = ~fault_latch;
    next_drv.first_power_good_oe_n =
      ~(in_lock | in_init | ~c.first_feedback_ok);
    next_drv.second_power_good_oe_n =
      ~(in_lock | in_init | ~c.second_feedback_ok);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv <= '{dcis_pkg::G_FAST, dcis_pkg::G_FAST, dcis_pkg::T_DN,
               1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    end else begin
      drv <= next_drv;
    end
  end

  // Open-drain pins only ever pull low; enables decide the level.
  assign fault_line_o        = 1'b0;
  assign first_power_good_o  = 1'b0;
  assign second_power_good_o = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle.

  logic        hit_ctrl;
  logic        hit_stat;
  logic        next_fitted;
  logic [31:0] next_prdata;
  logic [31:0] stat_word;

  assign hit_ctrl = paddr == `DCIS_CTRL_OFS;
  assign hit_stat = paddr == `DCIS_STAT_OFS;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~(hit_ctrl | hit_stat);

  always_comb begin
    stat_word = {13'h0000, armed, fault_latch, 5'h00, state};
    next_fitted = filter_fitted;
    if (psel && penable && pwrite && hit_ctrl) begin
      next_fitted = pwdata[`DCIS_CTRL_FILT];
    end
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (hit_ctrl) next_prdata[`DCIS_CTRL_FILT] = filter_fitted;
      if (hit_stat) next_prdata = stat_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_fitted <= 1'(`DCIS_CTRL_RST);
      prdata        <= 32'h0000_0000;
    end else begin
      filter_fitted <= next_fitted;
      prdata        <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic live;
  assign live = !latch_clr;

  sequence init_end_s;
    state == dcis_pkg::ST_INIT && c.timer_high && !en_cross && live;
  endsequence
  sequence idis_s;
    state == dcis_pkg::ST_IDIS;
  endsequence

  lock_outputs_a: assert property (in_lock |=>
    drv.first_gate_drive == dcis_pkg::G_FAST &&
    drv.second_gate_drive == dcis_pkg::G_FAST &&
    !drv.first_power_good_oe_n && !drv.second_power_good_oe_n)
    else $error("lockout outputs not forced");
  reset_gates_a: assert property (state == dcis_pkg::ST_RESET |=>
    drv.first_gate_drive == dcis_pkg::G_WEAK &&
    drv.second_gate_drive == dcis_pkg::G_WEAK && !fault_latch)
    else $error("reset state outputs wrong");
  ov_latch_a: assert property ((flt_out[1] || flt_out[2]) && live |=>
    fault_latch ##1 drv.first_gate_drive == dcis_pkg::G_FAST)
    else $error("overvoltage did not latch");
  fast_oc_a: assert property ((flt_out[3] || flt_out[4]) && live |=>
    fault_latch)
    else $error("fast overcurrent did not latch");
  ext_fault_a: assert property (!c.fault_line_high && live |=>
    fault_latch ##1 state == dcis_pkg::ST_FAULT || latch_clr)
    else $error("external fault not taken");
  fault_line_a: assert property (fault_latch |=> !drv.fault_oe_n)
    else $error("fault line not driven low");
  latch_cause_a: assert property ($rose(fault_latch) |->
    $past(fault_set) && !$past(latch_clr))
    else $error("latch set without cause");
  pg_init_a: assert property (in_init |=>
    !drv.first_power_good_oe_n && !drv.second_power_good_oe_n)
    else $error("power good high during timing");
  init_start_a: assert property (state == dcis_pkg::ST_OFF && init_go &&
    live && !lock_flt && !fault_latch |=> state == dcis_pkg::ST_INIT)
    else $error("initial timing did not start");
  restart_a: assert property (state == dcis_pkg::ST_INIT && en_cross &&
    live && !lock_flt && !fault_latch |=> state == dcis_pkg::ST_OFF)
    else $error("enable crossing did not restart");
  init_end_a: assert property (init_end_s and (!lock_flt &&
    !fault_latch) |=> idis_s)
    else $error("timer high did not discharge");
  arm_one_a: assert property (state == dcis_pkg::ST_UP1 && c.timer_high &&
    c.first_enable_on && live && !fault_latch |=> armed[0])
    else $error("channel one not armed");
  acl_hold_a: assert property (state == dcis_pkg::ST_UP1 && !armed[0] &&
    c.first_enable_on && c.first_acl_over && !in_lock && !fault_latch &&
    c.first_enable_rst |=> drv.first_gate_drive == dcis_pkg::G_HOLD)
    else $error("gate ramp not throttled");
  filter_up_a: assert property (slow_trip && !in_lock |=>
    drv.filter_pull_up)
    else $error("filter pull-up missing");

endmodule // dcis_sequencer
`default_nettype wire

// ---- inc/dcis_map.svh ----
/*
  Constants of the dual channel insertion sequencer: register offsets,
  field positions, reset values and filter timings.
  Assumes a 40 MHz pclk; cycle counts are derived from the period below.
*/
`ifndef DCIS_MAP_SVH
`define DCIS_MAP_SVH

// Clock period and filter times in ns.
`define DCIS_CLK_NS      25
`define DCIS_LOCK_T_NS   30000
`define DCIS_OV_T_NS     18000
`define DCIS_FAST_T_NS   1000
`define DCIS_SLOW_T_NS   15000
// Least time in cycles, rounded up.
`define DCIS_CYC(t) (((t) + `DCIS_CLK_NS - 1) / `DCIS_CLK_NS)

// Register map.
`define DCIS_CTRL_OFS    12'h000
`define DCIS_STAT_OFS    12'h004
`define DCIS_CTRL_RST    32'h0000_0000
`define DCIS_CTRL_FILT   0
`define DCIS_STAT_LATCH  16
`define DCIS_STAT_ARM    17

`endif

// ---- inc/dcis_pkg.sv ----
/*
  Types of the dual channel insertion sequencer: comparator inputs,
  drive outputs, drive modes and sequencer states.
  Assumes dcis_map.svh for the numeric constants.
*/
`default_nettype none
package dcis_pkg;

  // Gate drive modes.
  typedef enum logic [1:0] {
    G_WEAK = 2'h0, G_FAST = 2'h1, G_UP = 2'h2, G_HOLD = 2'h3
  } dcis_gate_t;

  // Timer pin modes.
  typedef enum logic [1:0] {
    T_DN = 2'h0, T_SMALL = 2'h1, T_LARGE = 2'h2, T_DIS = 2'h3
  } dcis_tmr_t;

  // Sequencer states, one-hot.
  typedef enum logic [10:0] {
    ST_LOCK = 11'h001, ST_RESET = 11'h002, ST_OFF = 11'h004,
    ST_INIT = 11'h008, ST_IDIS = 11'h010, ST_UP1 = 11'h020,
    ST_D1 = 11'h040, ST_UP2 = 11'h080, ST_D2 = 11'h100,
    ST_MON = 11'h200, ST_FAULT = 11'h400
  } dcis_state_t;

  // Comparator results, high when the named condition holds.
  typedef struct packed {
    logic first_supply_ok;
    logic second_supply_ok;
    logic first_enable_rst;
    logic first_enable_on;
    logic second_enable_on;
    logic first_sense_fast;
    logic second_sense_fast;
    logic first_sense_slow;
    logic second_sense_slow;
    logic first_acl_over;
    logic second_acl_over;
    logic first_feedback_ok;
    logic second_feedback_ok;
    logic first_feedback_ov;
    logic second_feedback_ov;
    logic fault_line_high;
    logic filter_high;
    logic timer_high;
    logic timer_low;
    logic first_gate_low;
    logic second_gate_low;
  } dcis_cmp_t;

  // Drive controls towards the analog pins.
  typedef struct packed {
    dcis_gate_t first_gate_drive;
    dcis_gate_t second_gate_drive;
    dcis_tmr_t  timer_mode;
    logic       filter_pull_up;
    logic       fault_pull_up;
    logic       fault_oe_n;
    logic       first_power_good_oe_n;
    logic       second_power_good_oe_n;
  } dcis_drv_t;

endpackage
`default_nettype wire

// ---- tb/dcis_far_model.sv ----
/*
  Far side model: timer capacitor, both gate nodes and the fault wire.
  Assumes the bench supplies every other comparator level through ext.
*/
`timescale 1ns/100ps
`default_nettype none
module dcis_far_model (
  // Clock
  input  wire logic                pclk,
  // Drive controls and bench levels
  input  wire dcis_pkg::dcis_drv_t drv,
  input  wire dcis_pkg::dcis_cmp_t ext,
  // Comparator levels
  output var  dcis_pkg::dcis_cmp_t cmp
);
  logic [6:0] tmr = 7'h00;
  logic [6:0] g1  = 7'h00;
  logic [6:0] g2  = 7'h00;

  // A node charges by a step, holds, or leaks down one unit a cycle.
  function automatic logic [6:0] ramp(input logic [6:0] v, input logic up,
      input logic hold, input logic [6:0] st);
    if (hold) return v;
    if (up) return (v > 7'h7F - st) ? 7'h7F : v + st;
    return (v > 7'h00) ? v - 7'h01 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Codes 1 and 2 source current; the large one charges twice as fast.
  always_ff @(posedge pclk) begin
    tmr <= ramp(tmr, ^drv.timer_mode, 1'b0, {5'h00, drv.timer_mode});
    g1  <= ramp(g1, drv.first_gate_drive == dcis_pkg::G_UP,
                drv.first_gate_drive == dcis_pkg::G_HOLD, 7'h02);
    g2  <= ramp(g2, drv.second_gate_drive == dcis_pkg::G_UP,
                drv.second_gate_drive == dcis_pkg::G_HOLD, 7'h02);
  end

  // Levels that the comparators see.
  always_comb begin
    cmp                 = ext;
    cmp.timer_high      = (tmr >= 7'h40);
    cmp.timer_low       = (tmr < 7'h08);
    cmp.first_gate_low  = (g1 < 7'h08);
    cmp.second_gate_low = (g2 < 7'h08);
    // The wire is low whenever either party pulls it down.
    cmp.fault_line_high = ext.fault_line_high & drv.fault_oe_n;
  end
endmodule // dcis_far_model
`default_nettype wire

// ---- tb/dcis_sequencer_tb.sv ----
/*
  Self-checking bench of the insertion sequencer.
  Assumes the far side model closes the timer and gate loops.
*/
`timescale 1ns/100ps
`default_nettype none
module dcis_sequencer_tb;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  dcis_pkg::dcis_cmp_t cmp_in;
  dcis_pkg::dcis_cmp_t ext;
  dcis_pkg::dcis_drv_t drv;
  logic [31:0]         rd;
  logic                rerr;
  wire  [2:0]          od;
  int                  errors = 0;
  int                  tests_run = 0;
  int                  cyc = 0;

  dcis_sequencer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmp_in, .drv,
    .fault_line_o(od[0]), .first_power_good_o(od[1]),
    .second_power_good_o(od[2]));
  dcis_far_model far (.pclk, .drv, .ext, .cmp(cmp_in));

  ////////////////////////////////////////////////////////////////////////
  // The small delay keeps the compare clear of updates at the edge.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd   = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls the state field, bounded so a stuck sequencer is reported.
  task automatic wait_st(input logic [10:0] s);
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, 12'h004, 32'h0);
      if (rd[10:0] === s) break;
    end
    chk({21'h0, rd[10:0]}, {21'h0, s});
  endtask

  // Global reset through the first enable, then back to the off state.
  task automatic recover;
    @(posedge pclk);
    ext.first_enable_rst <= 1'b0;
    ext.first_enable_on  <= 1'b0;
    ext.second_enable_on <= 1'b0;
    wait_st(dcis_pkg::ST_RESET);
    chk({31'h0, rd[16]}, 32'h0);
    chk({31'h0, drv.fault_oe_n}, 32'h1);
    @(posedge pclk);
    ext.first_enable_rst <= 1'b1;
    wait_st(dcis_pkg::ST_OFF);
  endtask

  // Raises or drops one fault cause.
  task automatic cause(input int k, input logic v);
    @(posedge pclk);
    case (k)
      0: ext.first_sense_fast <= v;
      1: ext.second_feedback_ov <= v;
      2: ext.first_feedback_ov <= v;
      4: ext.first_sense_slow <= v;
      default: ext.fault_line_high <= !v;
    endcase
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic s_boot;
    wait_st(dcis_pkg::ST_RESET);
    chk({30'h0, drv.first_gate_drive}, 32'h0);
    chk({30'h0, drv.second_gate_drive}, 32'h0);
    chk({31'h0, drv.fault_oe_n}, 32'h1);
    @(posedge pclk);
    ext.first_enable_rst <= 1'b1;
    wait_st(dcis_pkg::ST_OFF);
    chk({30'h0, drv.first_gate_drive}, 32'h0);
  endtask

  task automatic s_start;
    @(posedge pclk);
    ext.first_enable_on   <= 1'b1;
    ext.second_enable_on  <= 1'b1;
    ext.first_feedback_ok <= 1'b1;
    wait_st(dcis_pkg::ST_INIT);
    chk({30'h0, drv.timer_mode}, 32'h1);
    chk({31'h0, drv.first_power_good_oe_n}, 32'h0);
    // Dropping one enable mid-cycle must start the timing over, so the
    // sequencer is still timing long after the first cycle would end.
    repeat (20) @(posedge pclk);
    ext.second_enable_on <= 1'b0;
    repeat (58) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk({21'h0, rd[10:0]}, 32'h8);
    wait_st(dcis_pkg::ST_UP1);
    chk({30'h0, drv.first_gate_drive}, 32'h2);
    chk({30'h0, drv.timer_mode}, 32'h2);
    @(posedge pclk);
    ext.first_acl_over   <= 1'b1;
    ext.second_enable_on <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({30'h0, drv.first_gate_drive}, 32'h3);
    @(posedge pclk);
    ext.first_acl_over <= 1'b0;
    wait_st(dcis_pkg::ST_UP2);
    chk({30'h0, drv.second_gate_drive}, 32'h2);
    wait_st(dcis_pkg::ST_MON);
    chk({31'h0, drv.first_power_good_oe_n}, 32'h1);
  endtask

  task automatic s_fault(input int k, input int n);
    cause(k, 1'b1);
    if (k == 4) begin
      repeat (100) @(posedge pclk);
      chk({31'h0, drv.filter_pull_up}, 32'h1);
    end
    repeat (n) @(posedge pclk);
    cause(k, 1'b0);
    wait_st(dcis_pkg::ST_FAULT);
    chk({31'h0, rd[16]}, 32'h1);
    chk({31'h0, drv.fault_oe_n}, 32'h0);
    chk({31'h0, drv.fault_pull_up}, 32'h0);
    chk({29'h0, od}, 32'h0);
    chk({30'h0, drv.first_gate_drive}, 32'h1);
    chk({30'h0, drv.second_gate_drive}, 32'h1);
    recover();
  endtask

  // Dips and pulses shorter than their filters change nothing.
  task automatic s_glitch;
    cause(2, 1'b1);
    repeat (300) @(posedge pclk);
    cause(2, 1'b0);
    @(posedge pclk);
    ext.second_supply_ok <= 1'b0;
    repeat (200) @(posedge pclk);
    ext.second_supply_ok <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk({21'h0, rd[10:0]}, 32'h4);
  endtask

  task automatic s_lock;
    @(posedge pclk);
    ext.first_supply_ok <= 1'b0;
    repeat (1300) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0);
    chk({21'h0, rd[10:0]}, 32'h1);
    chk({31'h0, drv.first_power_good_oe_n}, 32'h0);
    chk({30'h0, drv.second_gate_drive}, 32'h1);
    chk({31'h0, drv.second_power_good_oe_n}, 32'h0);
    @(posedge pclk);
    ext.first_supply_ok <= 1'b1;
    wait_st(dcis_pkg::ST_OFF);
  endtask

  // Control reset value, read-back, read-only status, unmapped slot.
  task automatic s_apb;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk({21'h0, rd[10:0]}, 32'h4);
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      tally_and_finish();
    end
  end

  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    ext     = '0;
    ext.first_supply_ok  = 1'b1;
    ext.second_supply_ok = 1'b1;
    ext.fault_line_high  = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_boot();
    s_start();
    s_fault(4, 600);
    s_fault(0, 60);
    s_glitch();
    s_fault(2, 800);
    s_fault(1, 800);
    s_fault(3, 50);
    s_lock();
    s_apb();
    tally_and_finish();
  end
endmodule // dcis_sequencer_tb
`default_nettype wire
